// ===== common/blit_pkg.sv
// Register map, field layouts and thresholds of the blit status and command block
package blit_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] STATUS_OFS = 16'h8004;
  localparam logic [15:0] CMD_OFS = 16'h8008;
  localparam logic [15:0] CTRL_OFS = 16'h8040;
  localparam logic [15:0] DATA_OFS = 16'h8050;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 5;
  localparam logic [4:0] HALF_LEVEL = 5'h07;
  localparam logic [4:0] FULL_LEVEL = 5'h0f;
  localparam logic [4:0] RESUME_LEVEL = 5'h0e;
  localparam logic [3:0] OP_WRITE = 4'h0;
  localparam logic [3:0] OP_READ = 4'h1;
  localparam logic [3:0] OP_MOVE_POS = 4'h2;
  localparam logic [3:0] OP_MOVE_NEG = 4'h3;
  localparam logic [3:0] OP_PATTERN = 4'h6;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [2:0] rsvd_top;
    logic [4:0] used;
    logic [2:0] rsvd_mid;
    logic [4:0] free;
    logic [8:0] rsvd_low;
    logic not_empty;
    logic half_full;
    logic full;
    logic [2:0] rsvd_bot;
    logic busy;
  } status_t;

  typedef struct packed {
    logic [11:0] rsvd_hi;
    logic [3:0] rop;
    logic [11:0] rsvd_lo;
    logic [3:0] op;
  } cmd_t;

  typedef enum logic {FLOW_RUN, FLOW_PAUSED} flow_t;
endpackage

// ===== src/blit_status_and_rop_select.sv
// Blit engine status, command register, data FIFO and raster-operation unit
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module blit_status_and_rop_select #(
  parameter int DATA_W = 32,
  parameter int PIX_W = 16,
  parameter int DEPTH = blit_pkg::FIFO_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [blit_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic eng_done,
  input wire logic eng_push_valid,
  input wire logic [DATA_W-1:0] eng_push_data,
  output logic eng_push_ready,
  input wire logic eng_pop_req,
  output logic eng_pop_ack,
  output logic [DATA_W-1:0] eng_pop_data,
  output logic blit_start,
  output logic [3:0] blit_op,
  output logic [3:0] blit_rop,
  output logic [2:0] expand_start,
  input wire logic [PIX_W-1:0] rop_src,
  input wire logic [PIX_W-1:0] rop_pat,
  input wire logic [PIX_W-1:0] rop_dst,
  output logic [PIX_W-1:0] rop_result
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [blit_pkg::CNT_W-1:0] DEPTH_C = blit_pkg::CNT_W'(DEPTH);

  blit_pkg::cmd_t cmd, next_cmd;
  blit_pkg::flow_t flow, next_flow;
  logic busy, next_busy;
  logic start_q, next_start_q;
  logic [DATA_W-1:0] mem [DEPTH];
  logic [DATA_W-1:0] next_mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [blit_pkg::CNT_W-1:0] count, next_count;
  logic push_ready, next_push_ready;
  logic pop_ack, next_pop_ack;
  logic [DATA_W-1:0] pop_data, next_pop_data;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic data_rd_ok, next_data_rd_ok;
  logic [PIX_W-1:0] next_rop_result;

  logic setup_done, access;
  logic sel_status, sel_cmd, sel_ctrl, sel_data, mapped;
  logic host_push, host_pop, eng_push_ok, eng_pop_ok, do_push, do_pop, start_req;
  logic [DATA_W-1:0] push_word;
  logic [PIX_W-1:0] left_op;

  // Status word as software sees it; no internal pipeline, so used is exact
  function automatic blit_pkg::status_t make_status(
      input logic [blit_pkg::CNT_W-1:0] cnt, input logic bsy);
    blit_pkg::status_t s;
    s = blit_pkg::status_t'(blit_pkg::STATUS_RESET);
    s.used = cnt;
    s.free = DEPTH_C - cnt;
    s.not_empty = (cnt != '0);
    s.half_full = (cnt >= blit_pkg::HALF_LEVEL);
    s.full = (cnt >= blit_pkg::FULL_LEVEL);
    s.busy = bsy;
    return s;
  endfunction

  function automatic logic hit(input logic [blit_pkg::ADDR_W-1:0] a,
      input logic [15:0] ofs);
    return a[blit_pkg::ADDR_W-1:2] == ofs[15:2];
  endfunction

  always_comb begin
    sel_status = hit(paddr, blit_pkg::STATUS_OFS);
    sel_cmd = hit(paddr, blit_pkg::CMD_OFS);
    sel_ctrl = hit(paddr, blit_pkg::CTRL_OFS);
    sel_data = hit(paddr, blit_pkg::DATA_OFS);
    mapped = sel_status | sel_cmd | sel_ctrl | sel_data;
    setup_done = psel & penable & ~pready;
    access = psel & penable & pready & ~pslverr;

    // FIFO traffic; engine push has priority over a host data write
    eng_push_ok = eng_push_valid & push_ready;
    host_push = access & pwrite & sel_data & (count < DEPTH_C) & ~eng_push_ok;
    host_pop = access & ~pwrite & sel_data & data_rd_ok;
    // Engine pops wait while a host data read is in flight, so the word
    // returned on the bus is the one removed
    eng_pop_ok = eng_pop_req & (count != '0) & ~(psel & sel_data & ~pwrite);
    do_push = eng_push_ok | host_push;
    do_pop = host_pop | eng_pop_ok;
    push_word = eng_push_ok ? eng_push_data : pwdata[DATA_W-1:0];

    next_mem = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (do_push) begin
      next_mem[wr_ptr] = push_word;
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (do_pop) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
    next_count = count + blit_pkg::CNT_W'(do_push) - blit_pkg::CNT_W'(do_pop);
    next_pop_ack = eng_pop_ok;
    next_pop_data = eng_pop_ok ? mem[rd_ptr] : pop_data;

    // Command and start; a zero written to enable is never acted on
    next_cmd = cmd;
    if (access & pwrite & sel_cmd) begin
      next_cmd = blit_pkg::cmd_t'(pwdata);
      next_cmd.rsvd_hi = '0;
      next_cmd.rsvd_lo = '0;
    end
    start_req = access & pwrite & sel_ctrl & pwdata[blit_pkg::CTRL_ENABLE_BIT] & ~busy;
    next_start_q = start_req;
    if (start_req) begin
      next_busy = 1'b1;
    end else if (eng_done) begin
      next_busy = 1'b0;
    end else begin
      next_busy = busy;
    end

    // Read-blit flow: stop at full, restart below the resume level or once busy clears
    next_flow = flow;
    case (flow)
      blit_pkg::FLOW_RUN: begin
        if (next_count == DEPTH_C) begin
          next_flow = blit_pkg::FLOW_PAUSED;
        end
      end
      blit_pkg::FLOW_PAUSED: begin
        if (next_count < blit_pkg::RESUME_LEVEL || !next_busy) begin
          next_flow = blit_pkg::FLOW_RUN;
        end
      end
      default: next_flow = blit_pkg::FLOW_RUN;
    endcase
    // Ready is taken from next count so one accepted push never overfills
    next_push_ready = next_busy & (next_cmd.op == blit_pkg::OP_READ) &
                      (next_flow == blit_pkg::FLOW_RUN) & (next_count < DEPTH_C);

    // APB: one wait state, answer formed when the access phase opens
    next_pready = setup_done;
    next_pslverr = 1'b0;
    next_prdata = '0;
    next_data_rd_ok = data_rd_ok;
    if (setup_done) begin
      next_pslverr = ~mapped | (pwrite & sel_status);
      next_data_rd_ok = ~pwrite & sel_data & (count != '0);
      if (!pwrite) begin
        if (sel_status) begin
          next_prdata = make_status(count, busy);
        end else if (sel_cmd) begin
          next_prdata = cmd;
        end else if (sel_data && count != '0) begin
          next_prdata = 32'(mem[rd_ptr]);
        end
      end
    end else if (access) begin
      next_prdata = prdata;
    end

    // Raster operation; pattern fill takes the pattern as left operand
    left_op = (cmd.op == blit_pkg::OP_PATTERN) ? rop_pat : rop_src;
    for (int i = 0; i < PIX_W; i++) begin
      next_rop_result[i] = cmd.rop[{left_op[i], rop_dst[i]}];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= blit_pkg::cmd_t'(blit_pkg::CMD_RESET);
      flow <= blit_pkg::FLOW_RUN;
      busy <= 1'b0;
      start_q <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      push_ready <= 1'b0;
      pop_ack <= 1'b0;
      pop_data <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      data_rd_ok <= 1'b0;
      rop_result <= '0;
    end else if (ce) begin
      cmd <= next_cmd;
      flow <= next_flow;
      busy <= next_busy;
      start_q <= next_start_q;
      mem <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      push_ready <= next_push_ready;
      pop_ack <= next_pop_ack;
      pop_data <= next_pop_data;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      data_rd_ok <= next_data_rd_ok;
      rop_result <= next_rop_result;
    end
  end

  assign eng_push_ready = push_ready;
  assign eng_pop_ack = pop_ack;
  assign eng_pop_data = pop_data;
  assign blit_start = start_q;
  assign blit_op = cmd.op;
  assign blit_rop = cmd.rop;
  assign expand_start = cmd.rop[2:0];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  blit_pkg::status_t rd_stat;
  assign rd_stat = blit_pkg::status_t'(prdata);

  a_used_free_read: assert property (
    pready && !pslverr && !pwrite && sel_status |->
      rd_stat.used == $past(count) && rd_stat.used + rd_stat.free == DEPTH_C)
    else $error("status used/free do not match occupancy");
  a_band_flags: assert property (
    pready && !pslverr && !pwrite && sel_status |->
      (rd_stat.full ? rd_stat.half_full && rd_stat.not_empty : 1'b1) &&
      (rd_stat.half_full ? rd_stat.not_empty : 1'b1))
    else $error("occupancy band flags inconsistent");
  a_half_level: assert property (
    pready && !pslverr && !pwrite && sel_status |->
      rd_stat.half_full == ($past(count) >= 5'h07))
    else $error("half-full flag wrong for occupancy");
  a_empty_flag: assert property (
    pready && !pslverr && !pwrite && sel_status |->
      rd_stat.not_empty == (rd_stat.used != '0))
    else $error("not-empty flag disagrees with used count");
  a_pause_full: assert property (
    ce && count == DEPTH_C |=> !eng_push_ready)
    else $error("push accepted while FIFO full");
  a_stay_paused: assert property (
    ce && flow == blit_pkg::FLOW_PAUSED && count >= blit_pkg::RESUME_LEVEL &&
      !do_pop |=> !eng_push_ready)
    else $error("read blit resumed at fourteen or more words");
  a_start_busy: assert property (
    ce && start_req |=> busy && blit_start ##1 !blit_start || !ce)
    else $error("start did not raise busy for one pulse");
  a_done_idle: assert property (
    ce && busy && eng_done && !start_req |=> !busy)
    else $error("busy stayed high after done");
  // Top pixel bit only: stimulus keeps it clear, so the zero pair is really reached
  a_rop_zero_pair: assert property (
    ce && !rop_dst[PIX_W-1] && !rop_src[PIX_W-1] && cmd.op != blit_pkg::OP_PATTERN |=>
      rop_result[PIX_W-1] == $past(cmd.rop[0]))
    else $error("ROP bit 0 not applied for zero source and destination");
  a_cmd_readback: assert property (
    pready && !pslverr && !pwrite && sel_cmd |->
      prdata[31:20] == '0 && prdata[15:4] == '0)
    else $error("command reserved bits read nonzero");

  c_fill_pause: cover property (
    flow == blit_pkg::FLOW_PAUSED ##[1:200] flow == blit_pkg::FLOW_RUN);
  c_blit_cycle: cover property (blit_start ##[1:200] !busy);
  c_full_read: cover property (pready && sel_status && count == DEPTH_C);
  c_host_pop: cover property (host_pop && eng_push_ok);
endmodule

// ===== sim/engine_model.sv
// Behavioural engine side: offers read-blit words and asks for write-blit words
`timescale 1ns/1ps
module engine_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push_en,
  input wire logic pop_en,
  input wire logic push_ready,
  output logic push_valid,
  output logic [31:0] push_data,
  output logic pop_req
);
  logic [31:0] word;
  logic [31:0] next_word;
  always_comb begin
    next_word = word;
    if (push_valid && push_ready) begin
      next_word = word + 32'h0000_0001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word <= 32'h0000_0a00;
    end else begin
      word <= next_word;
    end
  end
  assign push_valid = push_en;
  // Idle data line shows the inverse so a stale word is never mistaken for a fresh one
  assign push_data = push_valid ? word : ~word;
  assign pop_req = pop_en;
endmodule

// ===== sim/testbench.sv
// Register-level test of the blit status and command block
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, eng_done;
  logic push_valid, push_ready, pop_req, pop_ack, blit_start, push_en, pop_en;
  logic [15:0] paddr, rop_src, rop_pat, rop_dst, rop_result;
  logic [31:0] pwdata, prdata, push_data, pop_data;
  logic [3:0] blit_op, blit_rop, op;
  logic [2:0] expand_start;
  int num_errors, samples_checked, cycles, pops, r, starts;
  blit_status_and_rop_select blit_status_and_rop_select_i (.pclk(pclk), .presetn(presetn),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eng_done(eng_done), .eng_push_valid(push_valid), .eng_push_data(push_data),
    .eng_push_ready(push_ready), .eng_pop_req(pop_req), .eng_pop_ack(pop_ack),
    .eng_pop_data(pop_data), .blit_start(blit_start), .blit_op(blit_op),
    .blit_rop(blit_rop), .expand_start(expand_start), .rop_src(rop_src),
    .rop_pat(rop_pat), .rop_dst(rop_dst), .rop_result(rop_result));
  engine_model engine_model_i (.pclk(pclk), .presetn(presetn), .push_en(push_en),
    .pop_en(pop_en), .push_ready(push_ready), .push_valid(push_valid),
    .push_data(push_data), .pop_req(pop_req));
  always #20 pclk = ~pclk;
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the pready edge
  task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                     input logic [31:0] exp, input logic exp_err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for pready; only the bench timeout ends this wait if it never comes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    chk(prdata, exp);
    chk({31'h0, pslverr}, {31'h0, exp_err});
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so the next setup never reassigns psel in this time step
    @(posedge pclk);
  endtask
  function automatic logic [31:0] st(input int c, input logic b);
    st = {3'h0, 5'(c), 3'h0, 5'(16 - c), 9'h0, c != 0, c >= 7, c >= 15, 3'h0, b};
  endfunction
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
    if (blit_start === 1'b1) begin
      starts++;
    end
    if (pop_ack === 1'b1) begin
      chk(pop_data, 32'h11 * (pops + 1));
      pops++;
    end
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, eng_done, push_en, pop_en} = 6'h00;
    paddr = 16'h0000;
    pwdata = 32'h0;
    rop_src = 16'h000c;
    rop_pat = 16'h0003;
    rop_dst = 16'h000a;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    acc(0, blit_pkg::STATUS_OFS, 0, st(0, 0), 0);
    acc(0, blit_pkg::CMD_OFS, 0, 32'h0, 0);
    acc(0, 16'h8000, 0, 32'h0, 1);
    acc(1, blit_pkg::STATUS_OFS, 32'h1, 32'h0, 1);
    for (r = 0; r < 16; r++) begin
      op = r[0] ? blit_pkg::OP_PATTERN : r[1] ? blit_pkg::OP_MOVE_NEG :
           r[2] ? blit_pkg::OP_MOVE_POS : blit_pkg::OP_WRITE;
      // Pattern fill must ignore the source, so the two swap places
      rop_src <= r[0] ? 16'h0003 : 16'h000c;
      rop_pat <= r[0] ? 16'h000c : 16'h0003;
      acc(1, blit_pkg::CMD_OFS, {12'h0, r[3:0], 12'h0, op}, 32'h0, 0);
      acc(0, blit_pkg::CMD_OFS, 0, {12'h0, r[3:0], 12'h0, op}, 0);
      chk({16'h0, rop_result}, {16'h0, {12{r[0]}}, r[3:0]});
      chk({29'h0, expand_start}, {29'h0, r[2:0]});
      chk({28'h0, blit_rop}, {28'h0, r[3:0]});
      chk({28'h0, blit_op}, {28'h0, op});
    end
    acc(1, blit_pkg::CMD_OFS, 32'h1, 32'h0, 0);
    acc(1, blit_pkg::CTRL_OFS, 32'h1, 32'h0, 0);
    acc(0, blit_pkg::STATUS_OFS, 0, st(0, 1), 0);
    // Enable written again while busy must not give a second start
    acc(1, blit_pkg::CTRL_OFS, 32'h1, 32'h0, 0);
    push_en <= 1'b1;
    repeat (40) @(posedge pclk);
    push_en <= 1'b0;
    acc(0, blit_pkg::STATUS_OFS, 0, st(16, 1), 0);
    chk({31'h0, push_ready}, 32'h0);
    for (r = 15; r >= 0; r--) begin
      acc(0, blit_pkg::DATA_OFS, 0, 32'h0a00 + 15 - r, 0);
      acc(0, blit_pkg::STATUS_OFS, 0, st(r, 1), 0);
      chk({31'h0, push_ready}, {31'h0, r < 14});
    end
    acc(0, blit_pkg::DATA_OFS, 0, 32'h0, 0);
    eng_done <= 1'b1;
    @(posedge pclk);
    eng_done <= 1'b0;
    acc(0, blit_pkg::STATUS_OFS, 0, st(0, 0), 0);
    acc(1, blit_pkg::CMD_OFS, 32'h0, 32'h0, 0);
    acc(1, blit_pkg::CTRL_OFS, 32'h1, 32'h0, 0);
    acc(1, blit_pkg::DATA_OFS, 32'h11, 32'h0, 0);
    acc(1, blit_pkg::DATA_OFS, 32'h22, 32'h0, 0);
    acc(0, blit_pkg::STATUS_OFS, 0, st(2, 1), 0);
    pop_en <= 1'b1;
    repeat (8) @(posedge pclk);
    pop_en <= 1'b0;
    chk(pops, 32'h2);
    chk(starts, 32'h2);
    give_verdict();
  end
endmodule
